// [rtl/hpc_pkg.sv]
// constants and types for the host parallel receive port
package hpc_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned CLK_HZ       = 25_000_000;
  // acknowledge pulse widths per speed setting, in nanoseconds
  localparam int unsigned ACK_SLOW_NS  = 2_000;
  localparam int unsigned ACK_MID_NS   = 1_000;
  localparam int unsigned ACK_FAST_NS  = 500;
  localparam int unsigned ACK_TURBO_NS = 200;
  localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ACK_SLOW_CYC  = ACK_SLOW_NS / CLK_NS;
  localparam int unsigned ACK_MID_CYC   = ACK_MID_NS / CLK_NS;
  localparam int unsigned ACK_FAST_CYC  = ACK_FAST_NS / CLK_NS;
  localparam int unsigned ACK_TURBO_CYC = ACK_TURBO_NS / CLK_NS;
  localparam int unsigned ACK_CNT_W     = 8;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  typedef enum logic [1:0] {
    XFER_COMPAT = 2'b00,
    XFER_NIBBLE = 2'b01,
    XFER_BYTE   = 2'b10,
    XFER_ECP    = 2'b11
  } xfer_mode_t;

  typedef enum logic [1:0] {
    SPD_SLOW  = 2'b00,
    SPD_MID   = 2'b01,
    SPD_FAST  = 2'b10,
    SPD_TURBO = 2'b11
  } speed_t;

  // gray sequence: idle -> wait rise -> wait sink -> ack
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_PUSH = 2'b11,
    ST_ACK  = 2'b10
  } rx_state_t;
endpackage

// [rtl/hpc_fifo.sv]
// synchronous valid/ready FIFO with parameterised width and depth
module hpc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk_i, // system clock
  input  wire logic             sys_rst_i, // synchronous reset
  input  wire logic [WIDTH-1:0] in_data_i, // write data
  input  wire logic             in_valid_i, // write request
  output logic                  in_ready_o, // not full
  output logic      [WIDTH-1:0] out_data_o, // head word
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i // consumer takes head
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             do_wr, do_rd;

  always_comb begin
    do_wr   = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
    do_rd   = out_ready_i && (cnt_r != '0);
    wp_nxt  = do_wr ? wp_r + AW'(1) : wp_r;
    rp_nxt  = do_rd ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
endmodule

// [rtl/host_parallel_channel.sv]
// receive side of the host parallel channel with strobe/busy/ack handshake
// Overview of operation
// - processor mode: processor reads each received command byte itself.
// - memory mode: received image bytes go straight to DRAM writes.
// - busy rises on every falling edge of the host strobe that arrives while idle.
// - eight data lines are latched on the strobe rising edge.
// - one acknowledge pulse per byte, width set by speed setting; memory mode stretches it until the buffer is drained.
// - busy falls at the trailing rising edge of acknowledge.
// - nibble, byte and ECP transfer modes are only reported on mode_o.
module host_parallel_channel
  import hpc_pkg::*;
(
  input  wire logic              sys_clk_i,      // 25 MHz system clock
  input  wire logic              sys_rst_i,      // synchronous reset, high
  input  wire logic              strobe_n_i,     // host strobe, active low
  input  wire logic [DATA_W-1:0] pdata_i,        // host data lines
  input  wire logic              dma_mode_i,     // 1 = direct memory mode
  input  wire logic [1:0]        speed_i,        // ack width setting
  input  wire logic [1:0]        xfer_mode_i,    // 1284 mode select
  input  wire logic              ecp_enable_i,   // later variant has ECP
  output logic                   busy_o,         // busy to host
  output logic                   ack_n_o,        // acknowledge, active low
  output logic                   cpu_valid_o,    // command byte available
  output logic [DATA_W-1:0]      cpu_data_o,     // command byte
  input  wire logic              cpu_read_i,     // processor read strobe
  output logic                   mem_req_o,      // DRAM write request
  output logic [DATA_W-1:0]      mem_data_o,     // DRAM write byte
  input  wire logic              mem_ack_i,      // DRAM write accepted
  output logic [1:0]             mode_o          // active transfer mode
);
  // strobe and data come from a pin: two flops before use
  logic              strb_s1_r;
  logic              strb_s2_r;
  logic              strb_s3_r;
  logic [DATA_W-1:0] dat_s1_r;
  logic [DATA_W-1:0] dat_s2_r;

  // the third strobe flop only feeds the edge detector; nothing but the
  // second flop may look at the first, which can still be metastable
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      strb_s1_r <= 1'b1;
      strb_s2_r <= 1'b1;
      strb_s3_r <= 1'b1;
    end else begin
      strb_s1_r <= strobe_n_i;
      strb_s2_r <= strb_s1_r;
      strb_s3_r <= strb_s2_r;
    end
  end

  // one synchroniser per data line; bits may settle on different edges,
  // which is harmless since the host holds data well past the strobe rise
  for (genvar b = 0; b < DATA_W; b++) begin : g_dat_sync
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
        dat_s1_r[b] <= DATA_RST[b];
        dat_s2_r[b] <= DATA_RST[b];
      end else begin
        dat_s1_r[b] <= pdata_i[b];
        dat_s2_r[b] <= dat_s1_r[b];
      end
    end
  end

  // reset presets the strobe pipe high, so no false edge follows reset
  logic strb_fall;
  logic strb_rise;
  assign strb_fall = strb_s3_r && !strb_s2_r;
  assign strb_rise = !strb_s3_r && strb_s2_r;

  // transfer mode select; ECP only when the variant allows it
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;

  always_comb begin
    mode_nxt = xfer_mode_i;
    if (xfer_mode_i == XFER_ECP && !ecp_enable_i) begin
      mode_nxt = XFER_COMPAT;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= XFER_COMPAT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ack width chosen from speed setting
  logic [ACK_CNT_W-1:0] ack_len;

  always_comb begin
    case (speed_t'(speed_i))
      SPD_SLOW:  ack_len = ACK_CNT_W'(ACK_SLOW_CYC);
      SPD_MID:   ack_len = ACK_CNT_W'(ACK_MID_CYC);
      SPD_FAST:  ack_len = ACK_CNT_W'(ACK_FAST_CYC);
      SPD_TURBO: ack_len = ACK_CNT_W'(ACK_TURBO_CYC);
      default:   ack_len = ACK_CNT_W'(ACK_SLOW_CYC);
    endcase
  end

  // receive fifo sits between the strobe capture and the consumers
  logic              f_in_valid;
  logic              f_in_ready;
  logic [DATA_W-1:0] f_out_data;
  logic              f_out_valid;
  logic              f_out_ready;

  // the memory request flag is needed by the release check below
  logic              mem_req_r;
  logic              mem_req_nxt;

  // handshake state: the sequencer and the acknowledge timer
  rx_state_t            st_r;
  rx_state_t            st_nxt;
  logic                 busy_r;
  logic                 busy_nxt;
  logic [DATA_W-1:0]    hold_r;
  logic [DATA_W-1:0]    hold_nxt;
  logic                 ack_n_r;
  logic                 ack_n_nxt;
  logic [ACK_CNT_W-1:0] cnt_r;
  logic [ACK_CNT_W-1:0] cnt_nxt;
  logic                 ack_start;
  logic                 ack_expired;
  logic                 may_release;

  // in memory mode busy stays up until every buffered byte is written,
  // so the host can never outrun the memory path
  assign may_release = !(dma_mode_i && (mem_req_r || f_out_valid));

  always_comb begin
    st_nxt     = st_r;
    busy_nxt   = busy_r;
    hold_nxt   = hold_r;
    f_in_valid = 1'b0;
    ack_start  = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (strb_fall) begin
          busy_nxt = 1'b1;
          st_nxt   = ST_LOW;
        end
      end
      ST_LOW: begin
        if (strb_rise) begin
          // synchronised data lags strobe equally, so it is still valid
          hold_nxt = dat_s2_r;
          st_nxt   = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // a full buffer stalls here with busy held, throttling the host
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          ack_start = 1'b1;
          st_nxt    = ST_ACK;
        end
      end
      ST_ACK: begin
        if (ack_expired && may_release) begin
          busy_nxt = 1'b0;
          st_nxt   = ST_IDLE;
        end
      end
      default: begin
        st_nxt   = ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  // acknowledge timer: loads the width on push, counts down to one, then
  // ends the pulse on the same edge at which busy falls
  assign ack_expired = (cnt_r <= ACK_CNT_W'(1));

  always_comb begin
    cnt_nxt   = cnt_r;
    ack_n_nxt = ack_n_r;
    if (ack_start) begin
      ack_n_nxt = 1'b0;
      cnt_nxt   = ack_len;
    end else if (!ack_n_r) begin
      if (!ack_expired) begin
        cnt_nxt = cnt_r - ACK_CNT_W'(1);
      end else if (may_release) begin
        ack_n_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r   <= ST_IDLE;
      busy_r <= 1'b0;
      hold_r <= DATA_RST;
    end else begin
      st_r   <= st_nxt;
      busy_r <= busy_nxt;
      hold_r <= hold_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_n_r <= 1'b1;
      cnt_r   <= '0;
    end else begin
      ack_n_r <= ack_n_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  hpc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (hold_r),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .out_data_o  (f_out_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready)
  );

  // consumers: processor holding register or memory write request; a
  // flag cleared and refilled in one cycle keeps the new byte
  logic              cpu_valid_r;
  logic              cpu_valid_nxt;
  logic [DATA_W-1:0] cpu_data_r;
  logic [DATA_W-1:0] cpu_data_nxt;
  logic [DATA_W-1:0] mem_data_r;
  logic [DATA_W-1:0] mem_data_nxt;
  logic              take_cpu;
  logic              take_mem;

  // a mode switch only redirects bytes not yet handed to a consumer
  assign take_cpu    = f_out_valid && !dma_mode_i &&
                       (!cpu_valid_r || cpu_read_i);
  assign take_mem    = f_out_valid && dma_mode_i &&
                       (!mem_req_r || mem_ack_i);
  assign f_out_ready = take_cpu || take_mem;

  always_comb begin
    cpu_valid_nxt = cpu_valid_r;
    cpu_data_nxt  = cpu_data_r;
    if (take_cpu) begin
      cpu_valid_nxt = 1'b1;
      cpu_data_nxt  = f_out_data;
    end else if (cpu_read_i) begin
      cpu_valid_nxt = 1'b0;
    end
  end

  always_comb begin
    mem_req_nxt  = mem_req_r;
    mem_data_nxt = mem_data_r;
    if (take_mem) begin
      mem_req_nxt  = 1'b1;
      mem_data_nxt = f_out_data;
    end else if (mem_ack_i) begin
      mem_req_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cpu_valid_r <= 1'b0;
      cpu_data_r  <= DATA_RST;
    end else begin
      cpu_valid_r <= cpu_valid_nxt;
      cpu_data_r  <= cpu_data_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mem_req_r  <= 1'b0;
      mem_data_r <= DATA_RST;
    end else begin
      mem_req_r  <= mem_req_nxt;
      mem_data_r <= mem_data_nxt;
    end
  end

  assign busy_o      = busy_r;
  assign ack_n_o     = ack_n_r;
  assign cpu_valid_o = cpu_valid_r;
  assign cpu_data_o  = cpu_data_r;
  assign mem_req_o   = mem_req_r;
  assign mem_data_o  = mem_data_r;
  assign mode_o      = mode_r;
endmodule

// [verif/hpc_host_model.sv]
// host computer side: strobes bytes into the receive port
module hpc_host_model
  import hpc_pkg::*;
(
  input  wire logic              sys_clk_i,  // system clock
  input  wire logic              busy_i,     // device busy
  output logic                   strobe_n_o, // host strobe
  output logic      [DATA_W-1:0] pdata_o     // host data lines
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    strobe_n_o = 1'b1;
    pdata_o    = 8'h00;
  end
  // ok stays 0 when the device never drops busy (buffer full)
  task automatic send(input logic [7:0] b, input int slow, output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 400 && busy_i !== 1'b0; n++) @(posedge sys_clk_i);
    if (busy_i !== 1'b0) return;
    pdata_o    <= b;
    strobe_n_o <= 1'b0;
    repeat (4 + slow) @(posedge sys_clk_i);
    strobe_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    // released lines must not keep showing the byte
    pdata_o <= ~b;
    ok = 1'b1;
  endtask
endmodule

// [verif/hpc_rx_chk.sv]
// assertions on the ports of the host parallel receive port
module hpc_rx_chk
  import hpc_pkg::*;
(
  input wire logic        sys_clk_i,    // clock
  input wire logic        sys_rst_i,    // reset
  input wire logic        strobe_n_i,   // strobe
  input wire logic        dma_mode_i,   // memory mode
  input wire logic [1:0]  speed_i,      // ack width
  input wire logic [1:0]  xfer_mode_i,  // mode request
  input wire logic        ecp_enable_i, // ecp allowed
  input wire logic        busy_o,       // busy
  input wire logic        ack_n_o,      // acknowledge
  input wire logic        cpu_valid_o,  // byte for cpu
  input wire logic [7:0]  cpu_data_o,   // cpu byte
  input wire logic        cpu_read_i,   // cpu takes
  input wire logic        mem_req_o,    // dram write
  input wire logic [7:0]  mem_data_o,   // dram byte
  input wire logic        mem_ack_i,    // dram takes
  input wire logic [1:0]  mode_o        // active mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] exp_w;
  always_comb begin
    cnt_nxt = ack_n_o ? 8'h00 : cnt_r + 8'h01;
    exp_w = 8'(ACK_SLOW_CYC);
    case (speed_i)
      SPD_MID: exp_w = 8'(ACK_MID_CYC);
      SPD_FAST: exp_w = 8'(ACK_FAST_CYC);
      SPD_TURBO: exp_w = 8'(ACK_TURBO_CYC);
      default: ;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    cnt_r <= sys_rst_i ? 8'h00 : cnt_nxt;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_busy_on_fall: assert property ($fell(strobe_n_i) && !busy_o && ack_n_o
    |-> ##[2:5] busy_o) else $error("busy did not follow strobe");
  a_busy_ack_end: assert property ($fell(busy_o) |-> $rose(ack_n_o))
    else $error("busy fell apart from ack end");
  a_ack_in_busy: assert property (!ack_n_o |-> busy_o)
    else $error("ack low while not busy");
  a_ack_width: assert property ($rose(ack_n_o) |-> (dma_mode_i ?
    cnt_r >= exp_w : cnt_r == exp_w)) else $error("ack width wrong");
  a_cpu_hold: assert property (cpu_valid_o && !cpu_read_i |=>
    cpu_valid_o && $stable(cpu_data_o)) else $error("cpu byte lost");
  a_mem_hold: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_data_o)) else $error("dram write lost");
  a_mem_route: assert property ($rose(mem_req_o) |-> $past(dma_mode_i))
    else $error("dram write in cpu mode");
  a_cpu_route: assert property ($rose(cpu_valid_o) |-> !$past(dma_mode_i))
    else $error("cpu byte in memory mode");
  a_dma_busy_wait: assert property ($fell(busy_o) && dma_mode_i |->
    !$past(mem_req_o) || $past(mem_ack_i)) else $error("busy left early");
  a_mode_follow: assert property (($stable(xfer_mode_i) &&
    $stable(ecp_enable_i))[*3] |-> mode_o == ((xfer_mode_i == XFER_ECP &&
    !ecp_enable_i) ? XFER_COMPAT : xfer_mode_i)) else $error("mode wrong");
  c_dma_ack: cover property ($rose(ack_n_o) && dma_mode_i);
  c_cpu_take: cover property (cpu_valid_o && cpu_read_i);
  c_mem_take: cover property (mem_req_o && mem_ack_i);
endmodule
bind host_parallel_channel hpc_rx_chk i_hpc_rx_chk (.*);

// [verif/test_host_parallel_channel.sv]
// self-checking bench for the host parallel receive port
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_host_parallel_channel
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, dma = 1'b0, ecp = 1'b0, rd = 1'b0;
  logic mack = 1'b0, drain = 1'b0, strb_n, busy, ack_n, cval, mreq;
  logic [1:0] spd = 2'b00, xm = 2'b00, mode;
  logic [7:0] pd, cdat, mdat, exp_q[$];
  int mismatches = 0, checks_done = 0, i;
  bit ok;
  always #20 clk = ~clk;
  host_parallel_channel i_host_parallel_channel (.sys_clk_i(clk),
    .sys_rst_i(rst), .strobe_n_i(strb_n), .pdata_i(pd), .dma_mode_i(dma),
    .speed_i(spd), .xfer_mode_i(xm), .ecp_enable_i(ecp), .busy_o(busy),
    .ack_n_o(ack_n), .cpu_valid_o(cval), .cpu_data_o(cdat),
    .cpu_read_i(rd), .mem_req_o(mreq), .mem_data_o(mdat),
    .mem_ack_i(mack), .mode_o(mode));
  hpc_host_model i_hpc_host_model (.sys_clk_i(clk), .busy_i(busy),
    .strobe_n_o(strb_n), .pdata_o(pd));
  task automatic take(input logic [7:0] v);
    logic [7:0] e;
    // a byte with nothing expected is a failure even if it is unknown
    if (exp_q.size() == 0) begin
      `CHK(1'b0, 1'b1)
    end else begin
      e = exp_q.pop_front();
      `CHK(v, e)
    end
  endtask
  // consumers stall at random, and stop while drain is low so the buffer really backs up
  always @(posedge clk) begin
    if (cval && rd) take(cdat);
    if (mreq && mack) take(mdat);
    rd   <= drain && ($urandom % 3 != 0);
    mack <= drain && ($urandom % 3 != 0);
  end
  task automatic burst(input int n, input logic [1:0] s, input logic d);
    logic [7:0] b;
    // older bytes must be consumed before the mode may switch consumers
    for (int k = 0; k < 2000 && (busy !== 1'b0 || exp_q.size() > 0); k++)
      @(posedge clk);
    spd <= s;
    dma <= d;
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      i_hpc_host_model.send(b, k % 3, ok);
      `CHK(ok, 1'b1)
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h18dc_f0f7));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 8; i++) begin
      xm  <= i[1:0];
      ecp <= i[2];
      repeat (5) @(posedge clk);
      `CHK(mode, (i[1:0] == 2'b11 && !i[2]) ? 2'b00 : i[1:0])
    end
    drain <= 1'b1;
    for (i = 0; i < 4; i++) burst(4, i[1:0], 1'b0);
    burst(0, 2'b11, 1'b0);
    drain <= 1'b0;
    for (i = 0; i < 24; i++) begin
      exp_q.push_back(8'($urandom));
      i_hpc_host_model.send(exp_q[$], 0, ok);
      if (!ok) break;
    end
    if (!ok) void'(exp_q.pop_back());
    `CHK(ok, 1'b0)
    `CHK(i == FIFO_DEPTH + 2, 1'b1)
    drain <= 1'b1;
    burst(12, 2'b10, 1'b1);
    for (i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
  initial begin
    #(40 * 60000);
    mismatches++;
    give_verdict();
  end
endmodule
